// ---- rrd_consts.svh ----
`ifndef RRD_CONSTS_SVH
`define RRD_CONSTS_SVH
// register indices, byte address is four times the index
`define RRD_IDX_CMD 6'h00
`define RRD_IDX_RING_START 6'h01
`define RRD_IDX_RING_STOP 6'h02
`define RRD_IDX_BOUNDARY 6'h03
`define RRD_IDX_TCR 6'h04
`define RRD_IDX_CURR 6'h07
`define RRD_IDX_RADDR_LO 6'h08
`define RRD_IDX_RADDR_HI 6'h09
`define RRD_IDX_WAKE 6'h0A
`define RRD_IDX_PM 6'h0B
`define RRD_IDX_RBCR0 6'h0C
`define RRD_IDX_RBCR1 6'h0D
`define RRD_IDX_DCR 6'h0E
`define RRD_IDX_ISR 6'h10
`define RRD_IDX_IMR 6'h11
`define RRD_IDX_DATA 6'h12
`define RRD_IDX_DADDR 6'h13
`define RRD_IDX_DCNT 6'h14
// command register fields
`define RRD_CMD_RST 8'h21
`define RRD_CMD_STOP 0
`define RRD_CMD_STA 1
`define RRD_CMD_XMIT 2
`define RRD_CMD_RD 3
`define RRD_RD_READ 3'h1
// transmit config loop-back field and mode
`define RRD_TCR_LB 1
`define RRD_LB_MODE1 2'h1
`define RRD_DCR_WORD 0
`define RRD_PM_SLEEP 0
// interrupt status bits
`define RRD_EV_RX 0
`define RRD_EV_OVF 1
`define RRD_EV_RDMA 2
`define RRD_EV_WAKE 3
// stored packet header length in bytes
`define RRD_HDR_BYTES 8'h04
`endif

// ---- rrd_pkg.sv ----
package rrd_pkg;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } rrd_beat_s;
    typedef struct packed {
        logic en;
        logic [15:0] addr;
        logic [7:0] data;
    } rrd_wr_s;
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_DATA = 4'b0010,
        RX_DROP = 4'b0100,
        RX_HDR = 4'b1000
    } rrd_rx_state_e;
endpackage

// ---- rrd_packet_buffer.sv ----
`timescale 1ns/1ps
module rrd_packet_buffer #(parameter int ADDR_W = 11) (
    // clock
    input wire logic clk_sys,
    // byte write port
    input wire rrd_pkg::rrd_wr_s wr,
    // word read port, low byte from rd_addr, high byte from the next address
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_word
);
    import rrd_pkg::*;
    localparam int BYTES = 2 ** ADDR_W;
    logic [7:0] mem_ff [BYTES];
    wire [ADDR_W-1:0] wa = wr.addr[ADDR_W-1:0];
    wire [ADDR_W-1:0] ra0 = rd_addr[ADDR_W-1:0];
    wire [ADDR_W-1:0] ra1 = ra0 + {{(ADDR_W-1){1'b0}}, 1'b1};
    always_ff @(posedge clk_sys) begin
        if (wr.en) begin
            mem_ff[wa] <= wr.data;
        end
    end
    assign rd_word = {mem_ff[ra1], mem_ff[ra0]};
endmodule // rrd_packet_buffer

// ---- rrd_rx_store.sv ----
`timescale 1ns/1ps
`include "rrd_consts.svh"
module rrd_rx_store (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // frame bytes in
    input wire rrd_pkg::rrd_beat_s beat,
    input wire logic accept,
    input wire logic [7:0] status,
    // ring pointers
    input wire logic [7:0] ring_start,
    input wire logic [7:0] ring_stop,
    input wire logic [7:0] boundary,
    input wire logic [7:0] curr,
    // buffer write and results
    output rrd_pkg::rrd_wr_s mem_wr,
    output logic [7:0] next_page,
    output logic curr_adv,
    output logic ovf
);
    import rrd_pkg::*;
    rrd_rx_state_e state_ff, nxt_state;
    logic [15:0] wptr_ff, len_ff;
    logic [1:0] hidx_ff;
    logic [7:0] npage_ff, hdr_byte;

    function automatic logic [7:0] page_inc(input logic [7:0] p, input logic [7:0] s0,
                                            input logic [7:0] s1);
        page_inc = (p + 8'h01 == s1) ? s0 : p + 8'h01;
    endfunction
    function automatic logic [15:0] addr_inc(input logic [15:0] a, input logic [7:0] s0,
                                             input logic [7:0] s1);
        addr_inc = (a[7:0] == 8'hFF) ? {page_inc(a[15:8], s0, s1), 8'h00}
                                     : {a[15:8], a[7:0] + 8'h01};
    endfunction

    wire is_idle = state_ff == RX_IDLE;
    wire is_data = state_ff == RX_DATA;
    wire is_hdr = state_ff == RX_HDR;
    wire full = boundary == curr;
    // accept is sampled only at frame start, so a frame under way completes
    wire start_ok = is_idle & beat.valid & accept & ~full;
    wire take = beat.valid & (start_ok | is_data);
    wire [15:0] wa = is_idle ? {curr, `RRD_HDR_BYTES} : wptr_ff;
    wire [15:0] na = addr_inc(wa, ring_start, ring_stop);
    wire hits = (na[7:0] == 8'h00) & (na[15:8] == boundary);
    wire [7:0] np = (na[7:0] == 8'h00) ? na[15:8] : page_inc(na[15:8], ring_start, ring_stop);
    wire [15:0] hdr_len = len_ff + 16'h0004;

    // header order: status, next page, count low, count high
    always_comb begin
        case (hidx_ff)
            2'h0: hdr_byte = status;
            2'h1: hdr_byte = npage_ff;
            2'h2: hdr_byte = hdr_len[7:0];
            default: hdr_byte = hdr_len[15:8];
        endcase
    end

    always_comb begin
        if (is_hdr) begin
            mem_wr = '{en: 1'b1, addr: {curr, 6'h00, hidx_ff}, data: hdr_byte};
        end else begin
            mem_wr = '{en: take, addr: wa, data: beat.data};
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            RX_IDLE, RX_DATA: begin
                if (take) begin
                    nxt_state = beat.last ? RX_HDR : (hits ? RX_DROP : RX_DATA);
                end else if (is_idle & beat.valid & ~beat.last) begin
                    nxt_state = RX_DROP;
                end
            end
            RX_DROP: begin
                if (beat.valid & beat.last) begin
                    nxt_state = RX_IDLE;
                end
            end
            RX_HDR: begin
                if (hidx_ff == 2'h3) begin
                    nxt_state = RX_IDLE;
                end
            end
            default: nxt_state = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff <= RX_IDLE;
            wptr_ff <= 16'h0000;
            len_ff <= 16'h0000;
            hidx_ff <= 2'h0;
            npage_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            hidx_ff <= is_hdr ? hidx_ff + 2'h1 : 2'h0;
            if (take) begin
                wptr_ff <= na;
                len_ff <= is_idle ? 16'h0001 : len_ff + 16'h0001;
                npage_ff <= np;
            end
        end
    end

    assign next_page = npage_ff;
    assign curr_adv = is_hdr & (hidx_ff == 2'h3);
    // overflow: ring full at start, or frame would run into the boundary page
    assign ovf = beat.valid & ((is_idle & accept & full) | (take & ~beat.last & hits));
endmodule // rrd_rx_store

// ---- rrd_remote_read_dma.sv ----
`timescale 1ns/1ps
`include "rrd_consts.svh"
module rrd_remote_read_dma #(parameter int ADDR_W = 11) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // mac streams
    input wire rrd_pkg::rrd_beat_s rx_beat,
    input wire rrd_pkg::rrd_beat_s tx_beat,
    input wire logic [7:0] rx_status,
    output logic tx_go,
    // wake detectors
    input wire logic wake_frame_hit,
    input wire logic magic_hit,
    input wire logic link_change,
    output logic wake_mode,
    // interrupt
    output logic irq
);
    import rrd_pkg::*;

    logic [7:0] cmd_ff, ring_start_ff, ring_stop_ff, boundary_ff, curr_ff, tcr_ff, dcr_ff;
    logic [7:0] wake_ff, pm_ff;
    logic [15:0] rsar_ff, rbcr_ff, daddr_ff, dcnt_ff;
    logic dact_ff, wr_pend_ff, tx_go_ff;
    logic [5:0] wr_idx_ff;
    logic [3:0] isr_ff, imr_ff;
    logic [31:0] hrdata_ff;
    logic [15:0] rd_word;
    logic [31:0] rd_val;
    rrd_wr_s mem_wr;
    logic [7:0] rx_next_page;
    logic curr_adv, rx_ovf;

    // bus decode; hsize is ignored, only whole words are supported
    wire addr_ph = hsel & htrans[1] & hready;
    wire in_map = haddr[31:8] == 24'h000000;
    wire [5:0] a_idx = haddr[7:2];
    wire rd_ph = addr_ph & ~hwrite;
    wire [7:0] wd = hwdata[7:0];

    function automatic logic is_wr(input logic pend, input logic [5:0] cur,
                                   input logic [5:0] idx);
        is_wr = pend & (cur == idx);
    endfunction

    wire w_cmd = is_wr(wr_pend_ff, wr_idx_ff, `RRD_IDX_CMD);
    wire w_curr = is_wr(wr_pend_ff, wr_idx_ff, `RRD_IDX_CURR);
    wire w_isr = is_wr(wr_pend_ff, wr_idx_ff, `RRD_IDX_ISR);

    // commands
    wire started = cmd_ff[`RRD_CMD_STA] & ~cmd_ff[`RRD_CMD_STOP];
    wire go_bits = wd[`RRD_CMD_STA] & ~wd[`RRD_CMD_STOP];
    wire stop_cmd = w_cmd & wd[`RRD_CMD_STOP];
    wire rd_go = w_cmd & go_bits & (wd[`RRD_CMD_RD+:3] == `RRD_RD_READ);
    wire xmit_cmd = w_cmd & go_bits & wd[`RRD_CMD_XMIT];

    // modes
    wire word_mode = dcr_ff[`RRD_DCR_WORD];
    wire loop1 = tcr_ff[`RRD_TCR_LB+:2] == `RRD_LB_MODE1;
    assign wake_mode = (wake_ff != 8'h00) & pm_ff[`RRD_PM_SLEEP];
    wire rx_accept = started & ~wake_mode;
    // in loop-back mode 1 the transmit stream replaces the line receive stream
    wire rrd_beat_s src = loop1 ? tx_beat : rx_beat;

    // remote read dma
    wire pop = rd_ph & in_map & (a_idx == `RRD_IDX_DATA) & dact_ff;
    wire [15:0] step = word_mode ? 16'h0002 : 16'h0001;
    wire [15:0] cnt_left = (dcnt_ff > step) ? dcnt_ff - step : 16'h0000;
    wire rdma_done = pop & (cnt_left == 16'h0000);
    wire [15:0] item = word_mode ? rd_word : {8'h00, rd_word[7:0]};

    // events: set wins over a same-cycle write-one clear
    wire wake_ev = wake_mode & (wake_frame_hit | magic_hit | link_change);
    wire [3:0] ev = {wake_ev, rdma_done, rx_ovf, curr_adv};
    wire [3:0] clr = w_isr ? wd[3:0] : 4'h0;
    wire [3:0] nxt_isr = (isr_ff & ~clr) | ev;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (in_map) begin
            case (a_idx)
                `RRD_IDX_CMD: rd_val[7:0] = cmd_ff;
                `RRD_IDX_RING_START: rd_val[7:0] = ring_start_ff;
                `RRD_IDX_RING_STOP: rd_val[7:0] = ring_stop_ff;
                `RRD_IDX_BOUNDARY: rd_val[7:0] = boundary_ff;
                `RRD_IDX_TCR: rd_val[7:0] = tcr_ff;
                `RRD_IDX_CURR: rd_val[7:0] = curr_ff;
                `RRD_IDX_RADDR_LO: rd_val[7:0] = rsar_ff[7:0];
                `RRD_IDX_RADDR_HI: rd_val[7:0] = rsar_ff[15:8];
                `RRD_IDX_WAKE: rd_val[7:0] = wake_ff;
                `RRD_IDX_PM: rd_val[7:0] = pm_ff;
                `RRD_IDX_RBCR0: rd_val[7:0] = rbcr_ff[7:0];
                `RRD_IDX_RBCR1: rd_val[7:0] = rbcr_ff[15:8];
                `RRD_IDX_DCR: rd_val[7:0] = dcr_ff;
                `RRD_IDX_ISR: rd_val[3:0] = isr_ff;
                `RRD_IDX_IMR: rd_val[3:0] = imr_ff;
                `RRD_IDX_DATA: rd_val[15:0] = dact_ff ? item : 16'h0000;
                `RRD_IDX_DADDR: rd_val[15:0] = daddr_ff;
                `RRD_IDX_DCNT: rd_val[15:0] = dcnt_ff;
                default: rd_val = 32'h0000_0000;
            endcase
        end
    end

    // bus pipeline: zero wait states, read data registered at the address edge
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 6'h00;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= addr_ph & hwrite & in_map;
            wr_idx_ff <= a_idx;
            hrdata_ff <= rd_ph ? rd_val : 32'h0000_0000;
        end
    end

    // command register; the transmit bit does not stay set
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cmd_ff <= `RRD_CMD_RST;
            tx_go_ff <= 1'b0;
        end else begin
            tx_go_ff <= xmit_cmd;
            if (w_cmd) begin
                cmd_ff <= wd & ~(8'h01 << `RRD_CMD_XMIT);
            end
        end
    end

    // plain configuration registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ring_start_ff <= 8'h00;
            ring_stop_ff <= 8'h00;
            boundary_ff <= 8'h00;
            tcr_ff <= 8'h00;
            dcr_ff <= 8'h00;
            wake_ff <= 8'h00;
            pm_ff <= 8'h00;
            rsar_ff <= 16'h0000;
            rbcr_ff <= 16'h0000;
            imr_ff <= 4'h0;
        end else if (wr_pend_ff) begin
            case (wr_idx_ff)
                `RRD_IDX_RING_START: ring_start_ff <= wd;
                `RRD_IDX_RING_STOP: ring_stop_ff <= wd;
                `RRD_IDX_BOUNDARY: boundary_ff <= wd;
                `RRD_IDX_TCR: tcr_ff <= wd;
                `RRD_IDX_DCR: dcr_ff <= wd;
                `RRD_IDX_WAKE: wake_ff <= wd;
                `RRD_IDX_PM: pm_ff <= wd;
                `RRD_IDX_RADDR_LO: rsar_ff[7:0] <= wd;
                `RRD_IDX_RADDR_HI: rsar_ff[15:8] <= wd;
                `RRD_IDX_RBCR0: rbcr_ff[7:0] <= wd;
                `RRD_IDX_RBCR1: rbcr_ff[15:8] <= wd;
                `RRD_IDX_IMR: imr_ff <= wd[3:0];
                default: ;
            endcase
        end
    end

    // current page: the receive advance wins over a host write
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            curr_ff <= 8'h00;
        end else if (curr_adv) begin
            curr_ff <= rx_next_page;
        end else if (w_curr) begin
            curr_ff <= wd;
        end
    end

    // remote dma address and count
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            daddr_ff <= 16'h0000;
            dcnt_ff <= 16'h0000;
            dact_ff <= 1'b0;
        end else if (stop_cmd) begin
            dact_ff <= 1'b0;
        end else if (rd_go) begin
            daddr_ff <= rsar_ff;
            dcnt_ff <= rbcr_ff;
            dact_ff <= rbcr_ff != 16'h0000;
        end else if (pop) begin
            daddr_ff <= daddr_ff + step;
            dcnt_ff <= cnt_left;
            dact_ff <= cnt_left != 16'h0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            isr_ff <= 4'h0;
        end else begin
            isr_ff <= nxt_isr;
        end
    end

    rrd_rx_store u_rx (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .beat(src),
        .accept(rx_accept),
        .status(rx_status),
        .ring_start(ring_start_ff),
        .ring_stop(ring_stop_ff),
        .boundary(boundary_ff),
        .curr(curr_ff),
        .mem_wr(mem_wr),
        .next_page(rx_next_page),
        .curr_adv(curr_adv),
        .ovf(rx_ovf)
    );

    rrd_packet_buffer #(.ADDR_W(ADDR_W)) u_buf (
        .clk_sys(clk_sys),
        .wr(mem_wr),
        .rd_addr(daddr_ff),
        .rd_word(rd_word)
    );

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign tx_go = tx_go_ff;
    assign irq = |(isr_ff & imr_ff);
endmodule // rrd_remote_read_dma

// ---- rrd_dma_assertions.sv ----
`timescale 1ns/1ps
`include "rrd_consts.svh"
module rrd_dma_assertions (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // controller outputs
    input wire logic tx_go,
    input wire logic wake_mode,
    input wire logic irq
);
    logic take;
    logic rtake;
    logic wtake;
    logic cmd_wr;
    assign take = hsel && htrans[1] && hready;
    assign rtake = take && !hwrite;
    assign wtake = take && hwrite;
    assign cmd_wr = wtake && haddr[31:8] == 24'h0 && haddr[7:2] == `RRD_IDX_CMD;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    AST_ZERO_WAIT: assert property (hreadyout) else $error("wait state");
    AST_OKAY: assert property (!hresp) else $error("error response");
    AST_RDATA_IDLE: assert property (!$past(rtake) |-> hrdata == 32'h0)
        else $error("read data outside a read");
    AST_RDATA_NARROW: assert property (hrdata[31:16] == 16'h0)
        else $error("read data too wide");
    AST_TXGO_PULSE: assert property (tx_go |=> !tx_go) else $error("long tx_go");
    // registers settle at the data phase edge, so the cause lies two edges back
    AST_TXGO_CAUSE: assert property (
        tx_go |-> $past(cmd_wr, 2) && $past(hwdata[2:0]) == 3'h6)
        else $error("tx_go without transmit command");
    AST_WAKE_BY_WRITE: assert property ($changed(wake_mode) |-> $past(wtake, 2))
        else $error("wake mode moved without a write");
    AST_IRQ_FALL_BY_WRITE: assert property ($fell(irq) |-> $past(wtake, 2))
        else $error("irq fell without a write");
    cover property (tx_go);
    cover property ($rose(wake_mode));
    cover property ($rose(irq));
endmodule // rrd_dma_assertions

bind rrd_remote_read_dma rrd_dma_assertions i_rrd_dma_assertions (.clk_sys(clk_sys),
    .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .tx_go(tx_go), .wake_mode(wake_mode), .irq(irq));

// ---- rrd_mac_model.sv ----
`timescale 1ns/1ps
module rrd_mac_model #(parameter logic [7:0] STAT = 8'h41) (
    // clock
    input wire logic clk_sys,
    // byte streams toward the controller
    output rrd_pkg::rrd_beat_s rx_beat,
    output rrd_pkg::rrd_beat_s tx_beat,
    output logic [7:0] rx_status
);
    import rrd_pkg::*;
    initial begin
        rx_beat = '0;
        tx_beat = '0;
        rx_status = STAT;
    end
    // call right after a rising edge; the idle tail covers the header writes
    task automatic send(input logic lb, input int n, input logic [7:0] b0);
        rrd_beat_s b;
        for (int i = 0; i < n; i++) begin
            b.valid = 1'b1;
            b.data = b0 + 8'(i);
            b.last = (i == n - 1);
            if (lb) tx_beat <= b; else rx_beat <= b;
            @(posedge clk_sys);
        end
        // released data shows the inverse so a stale byte can never look valid
        b.valid = 1'b0;
        b.data = ~b.data;
        b.last = 1'b0;
        if (lb) tx_beat <= b; else rx_beat <= b;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule // rrd_mac_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "rrd_consts.svh"
`define TB_CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; \
    $display("Error %s expected %0h seen %0h", nm, e, s); end end
module tb_top;
    import rrd_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    rrd_beat_s rx_beat;
    rrd_beat_s tx_beat;
    logic [7:0] rx_status;
    logic tx_go;
    logic [2:0] wev = 3'h0;
    logic wake_mode;
    logic irq;
    int fails = 0;
    int tests_run = 0;
    int txg = 0;
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (tx_go === 1'b1) txg++;
    rrd_mac_model i_rrd_mac_model (.clk_sys(clk_sys), .rx_beat(rx_beat), .tx_beat(tx_beat),
        .rx_status(rx_status));
    rrd_remote_read_dma i_rrd_remote_read_dma (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rx_beat(rx_beat), .tx_beat(tx_beat), .rx_status(rx_status), .tx_go(tx_go),
        .wake_frame_hit(wev[0]), .magic_hit(wev[1]), .link_change(wev[2]),
        .wake_mode(wake_mode), .irq(irq));
    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1 && ++n < 50);
        if (hreadyout !== 1'b1) fails++;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clk_sys); while (hreadyout !== 1'b1 && ++n < 100);
        if (hreadyout !== 1'b1) fails++;
        r = hrdata;
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, {24'h0, i, 2'h0}, d, r);
    endtask
    task automatic rd(input logic [5:0] i, output logic [31:0] r);
        bus(1'b0, {24'h0, i, 2'h0}, 8'h0, r);
    endtask
    task automatic chk(input logic [5:0] i, input logic [31:0] e);
        logic [31:0] r;
        rd(i, r);
        `TB_CHK($sformatf("register %0h", i), e, r)
    endtask
    task automatic rread(input logic [15:0] a, input logic [15:0] n, input logic [7:0] c);
        wr(`RRD_IDX_RADDR_LO, a[7:0]);
        wr(`RRD_IDX_RADDR_HI, a[15:8]);
        wr(`RRD_IDX_RBCR0, n[7:0]);
        wr(`RRD_IDX_RBCR1, n[15:8]);
        wr(`RRD_IDX_CMD, c);
    endtask
    task automatic t_reset();
        logic [31:0] r;
        bus(1'b1, 32'h0000_0100, 8'hFF, r);
        chk(`RRD_IDX_CMD, 32'h21);
        chk(`RRD_IDX_WAKE, 32'h0);
        chk(`RRD_IDX_PM, 32'h0);
        bus(1'b0, 32'h0000_0100, 8'h0, r);
        `TB_CHK("unmapped", 32'h0, r)
    endtask
    task automatic t_rx_byte();
        logic [31:0] r;
        logic [31:0] e;
        logic [7:0] hdr [4];
        hdr = '{8'h41, 8'h03, 8'h0A, 8'h00};
        wr(`RRD_IDX_RING_START, 8'h01);
        wr(`RRD_IDX_RING_STOP, 8'h07);
        wr(`RRD_IDX_BOUNDARY, 8'h01);
        wr(`RRD_IDX_CURR, 8'h02);
        wr(`RRD_IDX_IMR, 8'h0F);
        wr(`RRD_IDX_CMD, 8'h22);
        i_rrd_mac_model.send(1'b0, 6, 8'h10);
        `TB_CHK("irq on store", 1'b1, irq)
        chk(`RRD_IDX_CURR, 32'h03);
        rread(16'h0200, 16'h000A, 8'h0A);
        for (int k = 0; k < 10; k++) begin
            rd(`RRD_IDX_DATA, r);
            e = (k < 4) ? {24'h0, hdr[k]} : 32'h0C + k;
            `TB_CHK("byte", e, r)
        end
        rd(`RRD_IDX_DATA, r);
        `TB_CHK("after end", 32'h0, r)
        chk(`RRD_IDX_DADDR, 32'h020A);
        chk(`RRD_IDX_DCNT, 32'h0);
        chk(`RRD_IDX_ISR, 32'h05);
        wr(`RRD_IDX_ISR, 8'h05);
        @(negedge clk_sys);
        `TB_CHK("irq cleared", 1'b0, irq)
        @(posedge clk_sys);
        wr(`RRD_IDX_BOUNDARY, 8'h02);
    endtask
    task automatic t_word();
        logic [31:0] r;
        wr(`RRD_IDX_DCR, 8'h01);
        rread(16'h0200, 16'h0003, 8'h0A);
        rd(`RRD_IDX_DATA, r);
        `TB_CHK("word 0", 32'h0341, r)
        chk(`RRD_IDX_DADDR, 32'h0202);
        chk(`RRD_IDX_DCNT, 32'h01);
        rd(`RRD_IDX_DATA, r);
        `TB_CHK("word 1", 32'h000A, r)
        rd(`RRD_IDX_DATA, r);
        `TB_CHK("word 2", 32'h0, r)
        wr(`RRD_IDX_ISR, 8'h04);
        wr(`RRD_IDX_DCR, 8'h00);
    endtask
    task automatic t_full();
        wr(`RRD_IDX_BOUNDARY, 8'h03);
        i_rrd_mac_model.send(1'b0, 6, 8'h20);
        chk(`RRD_IDX_ISR, 32'h02);
        chk(`RRD_IDX_CURR, 32'h03);
        wr(`RRD_IDX_ISR, 8'h02);
        wr(`RRD_IDX_BOUNDARY, 8'h02);
    endtask
    task automatic t_stop();
        logic [31:0] r;
        fork
            i_rrd_mac_model.send(1'b0, 20, 8'h30);
            begin
                repeat (4) @(posedge clk_sys);
                wr(`RRD_IDX_CMD, 8'h21);
            end
        join
        chk(`RRD_IDX_CURR, 32'h04);
        rread(16'h0304, 16'h0002, 8'h09);
        rd(`RRD_IDX_DATA, r);
        `TB_CHK("stopped read", 32'h0, r)
        wr(`RRD_IDX_ISR, 8'h0F);
    endtask
    task automatic t_loop();
        logic [31:0] r;
        wr(`RRD_IDX_TCR, 8'h02);
        wr(`RRD_IDX_CMD, 8'h22);
        wr(`RRD_IDX_CMD, 8'h26);
        repeat (2) @(posedge clk_sys);
        `TB_CHK("tx_go pulses", 1, txg)
        i_rrd_mac_model.send(1'b1, 6, 8'h50);
        chk(`RRD_IDX_CURR, 32'h05);
        rread(16'h0404, 16'h0002, 8'h0A);
        for (int k = 0; k < 2; k++) begin
            rd(`RRD_IDX_DATA, r);
            `TB_CHK("looped byte", 32'h50 + k, r)
        end
        wr(`RRD_IDX_ISR, 8'h0F);
        wr(`RRD_IDX_TCR, 8'h00);
    endtask
    task automatic t_wake();
        wr(`RRD_IDX_WAKE, 8'h02);
        wr(`RRD_IDX_PM, 8'h01);
        @(negedge clk_sys);
        `TB_CHK("wake mode", 1'b1, wake_mode)
        @(posedge clk_sys);
        // the last pass repeats an event with its mask bit cleared
        for (int k = 0; k < 4; k++) begin
            wr(`RRD_IDX_IMR, k == 3 ? 8'h07 : 8'h0F);
            wev <= 3'(1 << (k % 3));
            @(posedge clk_sys);
            wev <= 3'h0;
            @(negedge clk_sys);
            `TB_CHK("wake irq", k != 3, irq)
            @(posedge clk_sys);
            chk(`RRD_IDX_ISR, 32'h08);
            wr(`RRD_IDX_ISR, 8'h08);
        end
        i_rrd_mac_model.send(1'b0, 6, 8'h60);
        chk(`RRD_IDX_CURR, 32'h05);
        wr(`RRD_IDX_PM, 8'h00);
        @(negedge clk_sys);
        `TB_CHK("wake mode off", 1'b0, wake_mode)
        @(posedge clk_sys);
    endtask
    task automatic end_of_test();
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_rx_byte();
        t_word();
        t_full();
        t_stop();
        t_loop();
        t_wake();
        end_of_test();
    end
    // the whole sequence needs about three hundred cycles
    initial begin
        #100000;
        fails++;
        end_of_test();
    end
endmodule // tb_top
